//--- common/jrs_cfg.svh
`ifndef JRS_CFG_SVH
`define JRS_CFG_SVH
`define JRS_DW 16
`define JRS_AW 6
// Register byte offsets
`define JRS_A_RAMP_TIME 6'h00
`define JRS_A_OFF_DELAY 6'h04
`define JRS_A_JOG_SPD1 6'h08
`define JRS_A_JOG_SPD2 6'h0C
`define JRS_A_STOP_SPD 6'h10
`define JRS_A_COMP_LVL 6'h14
`define JRS_A_CONFIG 6'h18
`define JRS_A_ARMV_GAIN 6'h1C
`define JRS_A_ARMV_OFS 6'h20
`define JRS_A_RATED_V 6'h24
`define JRS_A_TOP_SPD 6'h28
`define JRS_A_NEG_LIM 6'h2C
`define JRS_A_STATUS 6'h30
`define JRS_A_JOG_OUT 6'h34
`define JRS_A_COMP_OUT 6'h38
`define JRS_A_ARMV_OUT 6'h3C
// Config field positions
`define JRS_F_PERIOD 0
`define JRS_F_FB_LO 1
`define JRS_F_FB_HI 2
`define JRS_F_IN0_LO 3
`define JRS_F_IN0_HI 4
`define JRS_F_QUAD 5
`define JRS_IN0_JOG_SEL 2'h2
// Reset values
`define JRS_RST_RAMP 16'h001E
`define JRS_RST_OFF_DELAY 16'h000A
`define JRS_RST_JOG_SPD 16'h00FA
`define JRS_RST_STOP_SPD 16'h0032
`define JRS_RST_COMP 16'h0000
`define JRS_RST_GAIN 16'h03E8
`define JRS_RST_OFS 16'h0000
`define JRS_RST_RATED 16'h00F0
`define JRS_RST_TOP 16'h01F4
`define JRS_RST_NEG_LIM 16'h0064
`define JRS_RST_IN0 2'h1
// Legal ranges
`define JRS_RAMP_MIN 16'h0001
`define JRS_RAMP_MAX 16'h0BB8
`define JRS_DELAY_MAX 16'h0064
`define JRS_COMP_LIM 16'sh0032
`define JRS_GAIN_MIN 16'h02EE
`define JRS_GAIN_MAX 16'h04E2
`define JRS_OFS_LIM 16'sh00C8
`define JRS_RATED_MIN 16'h00A0
`define JRS_RATED_MAX 16'h02A3
`define JRS_TOP_MIN 16'h0005
`define JRS_TOP_MAX 16'h1388
// Scaling
`define JRS_PCT 100
`define JRS_MILLI 1000
`define JRS_TENTH_MS 100
`define JRS_ARMV_FS 4096
`define JRS_FRAC 8
// Timing
`define JRS_CLK_NS 100
`define JRS_P5_MS 5
`define JRS_P10_MS 10
`define JRS_NS_PER_MS 1000000
`define JRS_P5_CYC ((`JRS_P5_MS * `JRS_NS_PER_MS) / `JRS_CLK_NS)
`define JRS_P10_CYC ((`JRS_P10_MS * `JRS_NS_PER_MS) / `JRS_CLK_NS)
`define JRS_DIN_MS 10
`define JRS_DIN_CYC (((`JRS_DIN_MS * `JRS_NS_PER_MS) / `JRS_CLK_NS) + 1)
`endif

//--- common/jrs_pkg.sv
package jrs_pkg;
  // Feedback source selection
  typedef enum logic [1:0] {
    JRS_FB_ARMV = 2'h0,
    JRS_FB_DCT = 2'h1,
    JRS_FB_PULSE = 2'h2,
    JRS_FB_ACT = 2'h3
  } jrs_fb_t;
  // Contactor sequencing states
  typedef enum logic [2:0] {
    JRS_CT_OPEN = 3'b001,
    JRS_CT_JOG = 3'b010,
    JRS_CT_HOLD = 3'b100
  } jrs_ct_t;
endpackage

//--- core/jrs_ramp_step.sv
`timescale 1ns/10ps
// Linear rate limiter: moves value toward target by at most step per enable
module jrs_ramp_step #(
  parameter int W = 24
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Async reset, active high
  input wire logic i_ce, // Clock enable
  input wire logic i_en, // Update strobe
  input wire logic [W-1:0] i_target, // Target value
  input wire logic [W-1:0] i_step, // Largest change per update
  output logic [W-1:0] o_value // Ramped value
);
  logic [W-1:0] value_ff;
  logic [W-1:0] nxt_value;
  logic [W-1:0] diff;

  // Constant slope, no rounding stage: the last step lands on target
  always_comb begin
    nxt_value = value_ff;
    diff = '0;
    if (i_target > value_ff) begin
      diff = i_target - value_ff;
      nxt_value = (diff > i_step) ? W'(value_ff + i_step) : i_target;
    end else if (i_target < value_ff) begin
      diff = value_ff - i_target;
      nxt_value = (diff > i_step) ? W'(value_ff - i_step) : i_target;
    end
  end

  // Value register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      value_ff <= '0;
    end else if (i_ce && i_en) begin
      value_ff <= nxt_value;
    end
  end

  assign o_value = value_ff;

  property p_step_bound;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && i_en) |=> ((value_ff >= $past(value_ff)) ?
      (value_ff - $past(value_ff) <= $past(i_step)) :
      ($past(value_ff) - value_ff <= $past(i_step)));
  endproperty
  a_step_bound: assert property (p_step_bound)
    else $error("Ramp moved more than one step");
endmodule // jrs_ramp_step

//--- core/jrs_top.sv
`timescale 1ns/10ps
`include "jrs_cfg.svh"
module jrs_top
  import jrs_pkg::*;
#(
  parameter int P_P5_CYC = `JRS_P5_CYC,
  parameter int P_P10_CYC = `JRS_P10_CYC,
  parameter int P_DIN_CYC = `JRS_DIN_CYC
) (
  input wire logic I_CORE_CLK, // Core clock, 10 MHz
  input wire logic I_RESET, // Async reset, active high
  input wire logic I_CE, // Clock enable, freezes state when low
  input wire logic [`JRS_AW-1:0] I_ADDR, // Register byte address
  input wire logic [`JRS_DW-1:0] I_WDATA, // Write data
  input wire logic I_WR, // Write strobe
  input wire logic I_RD, // Read strobe
  output logic [`JRS_DW-1:0] O_RDATA, // Read data, cycle after strobe
  input wire logic I_JOG, // Jog request
  input wire logic I_DIN0, // Digital input 0 level
  input wire logic I_DRIVE_RUN, // Drive running
  input wire logic I_PULSE_KIT, // Pulse encoder kit present
  input wire logic I_ACT_KIT, // AC tach kit present
  input wire logic signed [`JRS_DW-1:0] I_SPEED_FB, // Speed feedback
  input wire logic signed [`JRS_DW-1:0] I_ARMV_RAW, // Conditioned armature volts
  input wire logic signed [`JRS_DW-1:0] I_CML_FB, // Inner current loop feedback
  input wire logic signed [`JRS_DW-1:0] I_RUN_REF, // Conditioned speed reference
  output logic O_CONTACTOR, // Main contactor closed
  output logic O_TICK, // Loop scan tick pulse
  output logic O_PERIOD_10MS, // Active period is 10 ms
  output logic [`JRS_DW-1:0] O_JOG_RAMP, // Ramped jog reference
  output logic signed [`JRS_DW-1:0] O_COMP_TERM, // Compounding term
  output logic signed [`JRS_DW-1:0] O_SPD_REF, // Reference after compounding
  output logic signed [`JRS_DW-1:0] O_ARMV_FB, // Armature voltage feedback
  output logic [`JRS_DW-1:0] O_NEG_LIM, // Negative current limit in force
  output logic O_REV_DISABLE // Reverse disable in force
);
  localparam int FW = `JRS_DW + `JRS_FRAC;

  // Settings
  logic [`JRS_DW-1:0] ramp_time_ff, off_delay_ff, jog_spd1_ff, jog_spd2_ff;
  logic [`JRS_DW-1:0] stop_spd_ff, gain_ff, rated_ff, top_ff, neg_lim_set_ff;
  logic signed [`JRS_DW-1:0] comp_lvl_ff, ofs_ff;
  logic period_sel_ff, quad_ff, reject_ff;
  jrs_fb_t fb_sel_ff;
  logic [1:0] in0_sel_ff;
  // Datapath state
  logic [31:0] scan_cnt_ff, din_cnt_ff, hold_ms_ff;
  logic din_on_ff, tick_ff, period10_ff, contactor_ff, rev_dis_ff;
  logic [`JRS_DW-1:0] neg_lim_ff, jog_out_ff;
  logic signed [`JRS_DW-1:0] comp_ff, spd_ref_ff, armv_ff;
  logic [`JRS_DW-1:0] rdata_ff;
  jrs_ct_t ct_ff, nxt_ct;
  // Combinational helpers
  logic wr_cfg, fb_ok, forced, active10, scan_end, delay_done, slow_enough;
  jrs_fb_t wr_fb;
  logic [31:0] period_ms, scan_last, step_wide;
  logic [FW-1:0] jog_target, jog_step, jog_value;
  logic [`JRS_DW-1:0] speed_mag, sel_spd;
  logic signed [31:0] comp_wide;
  logic signed [47:0] armv_wide;
  logic [`JRS_DW-1:0] nxt_rdata;

  // Config writes: period change only when stopped, tach kits checked
  assign wr_cfg = I_WR && (I_ADDR == `JRS_A_CONFIG);
  assign wr_fb = jrs_fb_t'(I_WDATA[`JRS_F_FB_HI:`JRS_F_FB_LO]);
  assign fb_ok = !((wr_fb == JRS_FB_PULSE) && !I_PULSE_KIT) &&
                 !((wr_fb == JRS_FB_ACT) && !I_ACT_KIT);

  // Software register writes; out-of-range values are refused and flagged
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ramp_time_ff <= `JRS_RST_RAMP;
      off_delay_ff <= `JRS_RST_OFF_DELAY;
      jog_spd1_ff <= `JRS_RST_JOG_SPD;
      jog_spd2_ff <= `JRS_RST_JOG_SPD;
      stop_spd_ff <= `JRS_RST_STOP_SPD;
      comp_lvl_ff <= `JRS_RST_COMP;
      gain_ff <= `JRS_RST_GAIN;
      ofs_ff <= `JRS_RST_OFS;
      rated_ff <= `JRS_RST_RATED;
      top_ff <= `JRS_RST_TOP;
      neg_lim_set_ff <= `JRS_RST_NEG_LIM;
      reject_ff <= 1'b0;
    end else if (I_CE && I_WR) begin
      reject_ff <= 1'b0;
      unique case (I_ADDR)
        `JRS_A_RAMP_TIME: begin
          if (I_WDATA >= `JRS_RAMP_MIN && I_WDATA <= `JRS_RAMP_MAX) ramp_time_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_OFF_DELAY: begin
          if (I_WDATA <= `JRS_DELAY_MAX) off_delay_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_JOG_SPD1: begin
          if (I_WDATA <= top_ff) jog_spd1_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_JOG_SPD2: begin
          if (I_WDATA <= top_ff) jog_spd2_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_STOP_SPD: begin
          if (I_WDATA <= top_ff) stop_spd_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_COMP_LVL: begin
          if ($signed(I_WDATA) >= -`JRS_COMP_LIM && $signed(I_WDATA) <= `JRS_COMP_LIM) begin
            comp_lvl_ff <= $signed(I_WDATA);
          end else reject_ff <= 1'b1;
        end
        `JRS_A_ARMV_GAIN: begin
          if (I_WDATA >= `JRS_GAIN_MIN && I_WDATA <= `JRS_GAIN_MAX) gain_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_ARMV_OFS: begin
          if ($signed(I_WDATA) >= -`JRS_OFS_LIM && $signed(I_WDATA) <= `JRS_OFS_LIM) begin
            ofs_ff <= $signed(I_WDATA);
          end else reject_ff <= 1'b1;
        end
        `JRS_A_RATED_V: begin
          if (I_WDATA >= `JRS_RATED_MIN && I_WDATA <= `JRS_RATED_MAX) rated_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_TOP_SPD: begin
          if (I_WDATA >= `JRS_TOP_MIN && I_WDATA <= `JRS_TOP_MAX) top_ff <= I_WDATA;
          else reject_ff <= 1'b1;
        end
        `JRS_A_NEG_LIM: neg_lim_set_ff <= I_WDATA;
        `JRS_A_CONFIG: reject_ff <= !fb_ok || (I_DRIVE_RUN &&
            (I_WDATA[`JRS_F_PERIOD] != period_sel_ff));
        default: reject_ff <= 1'b0;
      endcase
    end
  end

  // Config register; refused fields keep their old value
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      period_sel_ff <= 1'b0;
      fb_sel_ff <= JRS_FB_ARMV;
      in0_sel_ff <= `JRS_RST_IN0;
      quad_ff <= 1'b0;
    end else if (I_CE && wr_cfg) begin
      if (!I_DRIVE_RUN) period_sel_ff <= I_WDATA[`JRS_F_PERIOD];
      if (fb_ok) fb_sel_ff <= wr_fb;
      in0_sel_ff <= I_WDATA[`JRS_F_IN0_HI:`JRS_F_IN0_LO];
      quad_ff <= I_WDATA[`JRS_F_QUAD];
    end
  end

  // Active loop period and scan tick generator
  assign active10 = (fb_sel_ff == JRS_FB_ARMV) || period_sel_ff;
  assign period_ms = active10 ? 32'(`JRS_P10_MS) : 32'(`JRS_P5_MS);
  assign scan_last = active10 ? 32'(P_P10_CYC - 1) : 32'(P_P5_CYC - 1);
  assign scan_end = (scan_cnt_ff >= scan_last);
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      scan_cnt_ff <= '0;
      tick_ff <= 1'b0;
      period10_ff <= 1'b1;
    end else if (I_CE) begin
      scan_cnt_ff <= scan_end ? '0 : scan_cnt_ff + 32'd1;
      tick_ff <= scan_end;
      period10_ff <= active10;
    end
  end

  // Input 0 qualifier: on only after a sustained high, off immediately
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      din_cnt_ff <= '0;
      din_on_ff <= 1'b0;
    end else if (I_CE) begin
      if (!I_DIN0) begin
        din_cnt_ff <= '0;
        din_on_ff <= 1'b0;
      end else if (din_cnt_ff < 32'(P_DIN_CYC - 1)) begin
        din_cnt_ff <= din_cnt_ff + 32'd1;
      end else begin
        din_on_ff <= 1'b1;
      end
    end
  end

  // Jog speed choice and linear ramp step per tick
  assign sel_spd = ((in0_sel_ff == `JRS_IN0_JOG_SEL) && din_on_ff) ?
                   jog_spd2_ff : jog_spd1_ff;
  assign jog_target = (ct_ff == JRS_CT_JOG) ? {sel_spd, `JRS_FRAC'(0)} : '0;
  // Top speed over ramp time scaled to one tick; never below one LSB
  assign step_wide = (32'({top_ff, `JRS_FRAC'(0)}) * period_ms) /
                     (32'(ramp_time_ff) * 32'(`JRS_TENTH_MS));
  assign jog_step = (step_wide == '0) ? FW'(1) : FW'(step_wide);

  // Ramp has no rounding input at all
  jrs_ramp_step #(.W(FW)) u_jog_ramp (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RESET),
    .i_ce(I_CE),
    .i_en(tick_ff),
    .i_target(jog_target),
    .i_step(jog_step),
    .o_value(jog_value)
  );

  // Contactor sequencing; strict compare as the first tick may land just after release
  assign speed_mag = I_SPEED_FB[`JRS_DW-1] ? `JRS_DW'(-I_SPEED_FB) : I_SPEED_FB;
  assign slow_enough = (speed_mag <= stop_spd_ff);
  assign delay_done = (hold_ms_ff > 32'(off_delay_ff) * 32'(`JRS_TENTH_MS));
  always_comb begin
    nxt_ct = ct_ff;
    unique case (ct_ff)
      JRS_CT_OPEN: if (I_JOG) nxt_ct = JRS_CT_JOG;
      JRS_CT_JOG: if (!I_JOG) nxt_ct = JRS_CT_HOLD;
      JRS_CT_HOLD: begin
        if (I_JOG) nxt_ct = JRS_CT_JOG;
        else if (delay_done && slow_enough) nxt_ct = JRS_CT_OPEN;
      end
      default: nxt_ct = JRS_CT_OPEN;
    endcase
  end

  // Hold timer counts elapsed milliseconds one tick at a time
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ct_ff <= JRS_CT_OPEN;
      hold_ms_ff <= '0;
      contactor_ff <= 1'b0;
    end else if (I_CE) begin
      ct_ff <= nxt_ct;
      contactor_ff <= (nxt_ct != JRS_CT_OPEN);
      if (nxt_ct != JRS_CT_HOLD) hold_ms_ff <= '0;
      else if (tick_ff && !delay_done) hold_ms_ff <= hold_ms_ff + period_ms;
    end
  end

  // Compounding term and armature feedback, sampled once per tick
  assign comp_wide = (32'(I_CML_FB) * 32'(comp_lvl_ff)) / 32'sd`JRS_PCT;
  assign armv_wide = ((48'(I_ARMV_RAW) * 48'($signed({1'b0, rated_ff})) *
                       48'($signed({1'b0, gain_ff}))) /
                      48'sd`JRS_MILLI / 48'sd`JRS_ARMV_FS) + 48'(ofs_ff);
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      comp_ff <= '0;
      spd_ref_ff <= '0;
      armv_ff <= '0;
    end else if (I_CE && tick_ff) begin
      comp_ff <= `JRS_DW'(comp_wide);
      spd_ref_ff <= `JRS_DW'(I_RUN_REF - `JRS_DW'(comp_wide));
      armv_ff <= `JRS_DW'(armv_wide);
    end
  end

  // Unidirectional feedback forces the reverse limits
  assign forced = (fb_sel_ff == JRS_FB_ACT) ||
                  ((fb_sel_ff == JRS_FB_PULSE) && !quad_ff);
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      neg_lim_ff <= '0;
      rev_dis_ff <= 1'b0;
      jog_out_ff <= '0;
    end else if (I_CE) begin
      neg_lim_ff <= forced ? '0 : neg_lim_set_ff;
      rev_dis_ff <= forced;
      jog_out_ff <= jog_value[FW-1:`JRS_FRAC];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = '0;
    unique case (I_ADDR)
      `JRS_A_RAMP_TIME: nxt_rdata = ramp_time_ff;
      `JRS_A_OFF_DELAY: nxt_rdata = off_delay_ff;
      `JRS_A_JOG_SPD1: nxt_rdata = jog_spd1_ff;
      `JRS_A_JOG_SPD2: nxt_rdata = jog_spd2_ff;
      `JRS_A_STOP_SPD: nxt_rdata = stop_spd_ff;
      `JRS_A_COMP_LVL: nxt_rdata = comp_lvl_ff;
      `JRS_A_CONFIG: nxt_rdata = `JRS_DW'({quad_ff, in0_sel_ff, fb_sel_ff, period_sel_ff});
      `JRS_A_ARMV_GAIN: nxt_rdata = gain_ff;
      `JRS_A_ARMV_OFS: nxt_rdata = ofs_ff;
      `JRS_A_RATED_V: nxt_rdata = rated_ff;
      `JRS_A_TOP_SPD: nxt_rdata = top_ff;
      `JRS_A_NEG_LIM: nxt_rdata = neg_lim_set_ff;
      `JRS_A_STATUS: nxt_rdata = `JRS_DW'({reject_ff, din_on_ff, rev_dis_ff,
                                            period10_ff, contactor_ff});
      `JRS_A_JOG_OUT: nxt_rdata = jog_out_ff;
      `JRS_A_COMP_OUT: nxt_rdata = comp_ff;
      `JRS_A_ARMV_OUT: nxt_rdata = armv_ff;
      default: nxt_rdata = '0;
    endcase
  end

  // Read data stands one cycle only
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) rdata_ff <= '0;
    else if (I_CE) rdata_ff <= I_RD ? nxt_rdata : '0;
  end

  assign O_RDATA = rdata_ff;
  assign O_CONTACTOR = contactor_ff;
  assign O_TICK = tick_ff;
  assign O_PERIOD_10MS = period10_ff;
  assign O_JOG_RAMP = jog_out_ff;
  assign O_COMP_TERM = comp_ff;
  assign O_SPD_REF = spd_ref_ff;
  assign O_ARMV_FB = armv_ff;
  assign O_NEG_LIM = neg_lim_ff;
  assign O_REV_DISABLE = rev_dis_ff;

  // Checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  property p_open_delay;
    $fell(contactor_ff) |-> $past(delay_done);
  endproperty
  a_open_delay: assert property (p_open_delay)
    else $error("Contactor opened before off delay");
  property p_open_slow;
    $fell(contactor_ff) |-> $past(slow_enough);
  endproperty
  a_open_slow: assert property (p_open_slow)
    else $error("Contactor opened above stop speed");
  property p_jog_closed;
    (I_CE && I_JOG) |=> contactor_ff;
  endproperty
  a_jog_closed: assert property (p_jog_closed)
    else $error("Contactor not closed while jogging");
  property p_force_lim;
    (I_CE && forced) |=> (neg_lim_ff == '0 && rev_dis_ff);
  endproperty
  a_force_lim: assert property (p_force_lim)
    else $error("Negative limit not forced");
  property p_armv_10ms;
    (I_CE && fb_sel_ff == JRS_FB_ARMV) |=> period10_ff;
  endproperty
  a_armv_10ms: assert property (p_armv_10ms)
    else $error("Armature feedback not at 10 ms");
  property p_sel_period;
    (I_CE && fb_sel_ff != JRS_FB_ARMV) |=> (period10_ff == $past(period_sel_ff));
  endproperty
  a_sel_period: assert property (p_sel_period)
    else $error("Period not taken from setting");
  property p_run_lock;
    (I_CE && wr_cfg && I_DRIVE_RUN) |=> $stable(period_sel_ff);
  endproperty
  a_run_lock: assert property (p_run_lock)
    else $error("Period changed while running");
  property p_kit_check;
    (I_CE && wr_cfg && !fb_ok) |=> $stable(fb_sel_ff);
  endproperty
  a_kit_check: assert property (p_kit_check)
    else $error("Feedback accepted without kit");
  property p_tick_only;
    (I_CE && !tick_ff) |=> $stable(jog_value) && $stable(comp_ff);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("Update outside loop tick");
  property p_din_qual;
    $rose(din_on_ff) |-> $past(din_cnt_ff) == 32'(P_DIN_CYC - 1);
  endproperty
  a_din_qual: assert property (p_din_qual)
    else $error("Input 0 qualified too early");
endmodule // jrs_top

//--- verif/jrs_motor_model.sv
`timescale 1ns/10ps
// Motor behind the contactor: speed creeps toward the jog reference
module jrs_motor_model (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Async reset, active high
  input wire logic i_closed, // Main contactor closed
  input wire logic i_slow, // Heavy load, slow speed change
  input wire logic [15:0] i_ref, // Jog reference
  output logic signed [15:0] o_speed, // Speed feedback
  output logic signed [15:0] o_armv // Conditioned armature volts
);
  logic [5:0] div_ff;
  logic signed [15:0] speed_ff;
  logic signed [15:0] tgt;
  // An open contactor leaves the motor coasting down to rest
  assign tgt = i_closed ? $signed(i_ref) : 16'sh0000;
  // One unit per cycle, or per 64 cycles under load, so feedback lags the ramp
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 6'h00;
      speed_ff <= 16'sh0000;
    end else begin
      div_ff <= div_ff + 6'h01;
      if (!i_slow || div_ff == 6'h00) begin
        if (speed_ff < tgt) speed_ff <= speed_ff + 16'sh0001;
        else if (speed_ff > tgt) speed_ff <= speed_ff - 16'sh0001;
      end
    end
  end
  // Armature volts track speed at 16 counts per RPM
  assign o_speed = speed_ff;
  assign o_armv = speed_ff <<< 4;
endmodule // jrs_motor_model

//--- verif/jrs_top_tb_top.sv
`timescale 1ns/10ps
`include "jrs_cfg.svh"
module jrs_top_tb_top;
  localparam int P10 = 100;
  localparam int TENTH = 10 * P10; // Cycles in 0.1 s
  typedef struct {
    logic run, pk, ak;
    logic [15:0] w, e;
    logic p10;
    logic [15:0] neg;
    logic rev;
  } jrs_row_t;
  // Config rows: run, kits, written, read back, period, limit, reverse off
  jrs_row_t rows [9] = '{
    '{1'b0, 1'b0, 1'b0, 16'h0012, 16'h0012, 1'b0, 16'h0064, 1'b0},
    '{1'b1, 1'b0, 1'b0, 16'h0013, 16'h0012, 1'b0, 16'h0064, 1'b0},
    '{1'b0, 1'b0, 1'b0, 16'h0014, 16'h0012, 1'b0, 16'h0064, 1'b0},
    '{1'b0, 1'b0, 1'b0, 16'h0016, 16'h0012, 1'b0, 16'h0064, 1'b0},
    '{1'b0, 1'b1, 1'b0, 16'h0014, 16'h0014, 1'b0, 16'h0000, 1'b1},
    '{1'b0, 1'b1, 1'b0, 16'h0034, 16'h0034, 1'b0, 16'h0064, 1'b0},
    '{1'b0, 1'b0, 1'b1, 16'h0017, 16'h0017, 1'b1, 16'h0000, 1'b1},
    '{1'b1, 1'b0, 1'b0, 16'h0010, 16'h0011, 1'b1, 16'h0064, 1'b0},
    '{1'b0, 1'b0, 1'b0, 16'h0010, 16'h0010, 1'b1, 16'h0064, 1'b0}};
  logic clk, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, jog = 1'b0, din = 1'b0, run = 1'b0;
  logic pkit = 1'b0, akit = 1'b0, slow = 1'b0, ce = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000, rdata, jramp, neg_lim, v0;
  logic signed [15:0] spd, armv, inner_current_loop = 16'sh0000, rref = 16'sh0000, comp, sref, armv_fb;
  logic cont, tck, p10, rev;
  int bad_count = 0, total_checks = 0, g;
  jrs_top #(.P_P5_CYC(50), .P_P10_CYC(P10), .P_DIN_CYC(11)) uut (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_JOG(jog), .I_DIN0(din),
    .I_DRIVE_RUN(run), .I_PULSE_KIT(pkit), .I_ACT_KIT(akit), .I_SPEED_FB(spd),
    .I_ARMV_RAW(armv), .I_CML_FB(inner_current_loop), .I_RUN_REF(rref), .O_CONTACTOR(cont),
    .O_TICK(tck), .O_PERIOD_10MS(p10), .O_JOG_RAMP(jramp), .O_COMP_TERM(comp),
    .O_SPD_REF(sref), .O_ARMV_FB(armv_fb), .O_NEG_LIM(neg_lim), .O_REV_DISABLE(rev));
  jrs_motor_model u_motor (.i_clk(clk), .i_rst(rst), .i_closed(cont), .i_slow(slow),
    .i_ref(jramp), .o_speed(spd), .o_armv(armv));
  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus tasks start in the step of a rising edge; the idle edge avoids double strobes
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input string n, input logic [5:0] a, input logic [15:0] e,
                        input logic [15:0] m = 16'hFFFF);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    chk(n, e, rdata & m);
  endtask
  task automatic wr_rd(input logic [5:0] a, input logic [15:0] d, input logic [15:0] e);
    wr(a, d);
    rd_chk("readback", a, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      for (int k = 0; k < 300 && tck !== 1'b1; k++) @(posedge clk);
      if (tck !== 1'b1) bad_count++;
    end
  endtask
  // Release jog and time the contactor opening against speed and delay
  task automatic stop_chk(input logic [15:0] dly, input logic slow_m);
    int t;
    wr(`JRS_A_OFF_DELAY, dly);
    slow <= slow_m;
    jog <= 1'b0;
    t = 0;
    while (cont === 1'b1 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    chk("open_speed", 16'h0001, {15'h0, spd <= 16'sh0032});
    chk("open_early", 16'h0001, {15'h0, t >= int'(dly) * TENTH});
    chk("open_late", 16'h0001, {15'h0, t <= int'(dly) * TENTH + 300 || spd > 16'sh0028});
  endtask
  // Hang guard, well past the expected run length
  initial begin
    #10_000_000;
    bad_count++;
    end_of_test();
  end
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(3);
    chk("contactor", 16'h0000, {15'h0, cont});
    chk("period", 16'h0001, {15'h0, p10});
    rd_chk("ramp", `JRS_A_RAMP_TIME, 16'h001E);
    rd_chk("delay", `JRS_A_OFF_DELAY, 16'h000A);
    rd_chk("speed2", `JRS_A_JOG_SPD2, 16'h00FA);
    rd_chk("stop", `JRS_A_STOP_SPD, 16'h0032);
    rd_chk("gain", `JRS_A_ARMV_GAIN, 16'h03E8);
    rd_chk("config", `JRS_A_CONFIG, 16'h0008);
    foreach (rows[i]) begin
      run <= rows[i].run;
      pkit <= rows[i].pk;
      akit <= rows[i].ak;
      @(posedge clk);
      wr_rd(`JRS_A_CONFIG, rows[i].w, rows[i].e);
      tick(1);
      g = 0;
      do begin
        @(posedge clk);
        g++;
      end while (tck !== 1'b1 && g < 300);
      chk("period", {15'h0, rows[i].p10}, {15'h0, p10});
      chk("gap", rows[i].p10 ? 16'h0064 : 16'h0032, g[15:0]);
      chk("neg_lim", rows[i].neg, neg_lim);
      chk("reverse", {15'h0, rows[i].rev}, {15'h0, rev});
    end
    wr_rd(`JRS_A_RAMP_TIME, 16'h0000, 16'h001E);
    rd_chk("refused", `JRS_A_STATUS, 16'h0010, 16'h0010);
    wr_rd(`JRS_A_RAMP_TIME, 16'h0BB9, 16'h001E);
    wr_rd(`JRS_A_OFF_DELAY, 16'h0065, 16'h000A);
    wr_rd(`JRS_A_COMP_LVL, 16'h0033, 16'h0000);
    wr_rd(`JRS_A_ARMV_GAIN, 16'h02ED, 16'h03E8);
    wr_rd(`JRS_A_STOP_SPD, 16'h01F5, 16'h0032);
    rd_chk("unmapped", 6'h01, 16'h0000);
    wr_rd(`JRS_A_RAMP_TIME, 16'h000A, 16'h000A);
    rd_chk("refused", `JRS_A_STATUS, 16'h0000, 16'h0010);
    wr_rd(`JRS_A_JOG_SPD1, 16'h0100, 16'h0100);
    wr_rd(`JRS_A_JOG_SPD2, 16'h0064, 16'h0064);
    wr_rd(`JRS_A_ARMV_OFS, 16'h000A, 16'h000A);
    wr_rd(`JRS_A_ARMV_GAIN, 16'h04E2, 16'h04E2);
    wr_rd(`JRS_A_COMP_LVL, 16'hFFCE, 16'hFFCE);
    inner_current_loop <= 16'sh00C8;
    rref <= 16'sh03E8;
    tick(2);
    cyc(2);
    chk("comp", 16'hFF9C, comp);
    chk("spd_ref", 16'h044C, sref);
    chk("armv_zero", 16'h000A, armv_fb);
    rd_chk("comp_out", `JRS_A_COMP_OUT, 16'hFF9C);
    din <= 1'b1;
    cyc(8);
    rd_chk("din_short", `JRS_A_STATUS, 16'h0000, 16'h0008);
    cyc(4);
    rd_chk("din_on", `JRS_A_STATUS, 16'h0008, 16'h0008);
    din <= 1'b0;
    cyc(2);
    rd_chk("din_off", `JRS_A_STATUS, 16'h0000, 16'h0008);
    jog <= 1'b1;
    cyc(2);
    chk("contactor", 16'h0001, {15'h0, cont});
    tick(2);
    cyc(3);
    v0 = jramp;
    // Clock enable low must freeze the ramp across at least two scan periods
    ce <= 1'b0;
    cyc(250);
    chk("freeze", v0, jramp);
    ce <= 1'b1;
    tick(10);
    cyc(3);
    chk("slope", v0 + 16'h0032, jramp);
    tick(50);
    cyc(3);
    chk("jog1", 16'h0100, jramp);
    rd_chk("jog_out", `JRS_A_JOG_OUT, 16'h0100);
    chk("armv_fb", 16'h0136, armv_fb);
    din <= 1'b1;
    tick(40);
    cyc(3);
    chk("jog2", 16'h0064, jramp);
    stop_chk(16'h0002, 1'b0);
    jog <= 1'b1;
    tick(25);
    stop_chk(16'h0000, 1'b1);
    // Reset in mid-run brings every setting back to its default
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(3);
    chk("contactor", 16'h0000, {15'h0, cont});
    rd_chk("config", `JRS_A_CONFIG, 16'h0008);
    rd_chk("delay", `JRS_A_OFF_DELAY, 16'h000A);
    end_of_test();
  end
endmodule // jrs_top_tb_top
